// file: verilog/cmas_regs.svh
`ifndef CMAS_REGS_SVH
`define CMAS_REGS_SVH

// Working register indices within the bank
`define CMAS_IDX_X 3'h0
`define CMAS_IDX_A 3'h1
`define CMAS_IDX_C 3'h2
`define CMAS_IDX_B 3'h3
`define CMAS_IDX_E 3'h4
`define CMAS_IDX_D 3'h5
`define CMAS_IDX_L 3'h6
`define CMAS_IDX_H 3'h7

// Register pair codes
`define CMAS_RP_AX 2'h0
`define CMAS_RP_BC 2'h1
`define CMAS_RP_DE 2'h2
`define CMAS_RP_HL 2'h3

// Flag positions in the program status word
`define CMAS_PSW_Z  3'h6
`define CMAS_PSW_AC 3'h4
`define CMAS_PSW_CY 3'h0

// Operand address windows
`define CMAS_SADDR_LO    16'hFE20
`define CMAS_SADDR_HI    16'hFF1F
`define CMAS_SADDR_WRAP  8'h20
`define CMAS_PAGE_FF     8'hFF
`define CMAS_PAGE_FE     8'hFE
`define CMAS_SFR_HOLE_LO 16'hFFD0
`define CMAS_SFR_HOLE_HI 16'hFFDF
`define CMAS_SFRP_LO     16'hFF10
`define CMAS_SFRP_HI     16'hFF1F
`define CMAS_A11_BASE    5'h01
`define CMAS_A11_LO      16'h0800
`define CMAS_A11_HI      16'h0FFF
`define CMAS_A5_LO       16'h0040
`define CMAS_A5_HI       16'h007F
`define CMAS_HSRAM_LO    16'hFB00
`define CMAS_HSRAM_HI    16'hFEFF

// Reset values
`define CMAS_RST_BYTE 8'h00
`define CMAS_RST_PSW  8'h00

// Instruction clock counts
`define CMAS_CYC_REG   4'h2
`define CMAS_CYC_SHORT 4'h4
`define CMAS_CYC_MID   4'h6
`define CMAS_CYC_LONG  4'h8
`define CMAS_CYC_WABS  4'hA
`define CMAS_CYC_EXT1  4'h1
`define CMAS_CYC_EXT2  4'h2

`endif

// file: verilog/cmas_pkg.sv
package cmas_pkg;

	typedef enum logic [3:0] {
		OP_MOV    = 4'b0000,
		OP_XCH    = 4'b0001,
		OP_WORD_MOVE   = 4'b0010,
		OP_WORD_SWAP   = 4'b0011,
		OP_ADD    = 4'b0100,
		OP_ADD_WITH_CARRY   = 4'b0101,
		OP_SUB    = 4'b0110,
		OP_TARGET = 4'b0111
	} cmas_op_e;

	typedef enum logic [3:0] {
		AK_NONE   = 4'b0000,
		AK_SADDR  = 4'b0001,
		AK_SFR    = 4'b0010,
		AK_ABS    = 4'b0011,
		AK_DE     = 4'b0100,
		AK_HL     = 4'b0101,
		AK_HLBYTE = 4'b0110,
		AK_HLB    = 4'b0111,
		AK_HLC    = 4'b1000,
		AK_PSW    = 4'b1001,
		AK_ELEVEN_BIT_CALL_OPERAND = 4'b1010,
		AK_VECTOR_TABLE_OPERAND  = 4'b1011
	} cmas_ak_e;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} cmas_state_e;

	typedef logic [2:0] cmas_bit_t;

	typedef struct packed {
		cmas_op_e    op;
		cmas_ak_e    ak;
		logic        use_imm;
		logic        to_mem;
		logic        r_dst;
		logic [2:0]  reg_sel;
		logic [1:0]  rp_sel;
		cmas_bit_t   bit_pos;
		logic [15:0] addr;
		logic [15:0] imm;
	} cmas_req_s;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} cmas_mem_s;

	typedef struct packed {
		cmas_state_e     state;
		cmas_req_s       cmd;
		logic [15:0]     ea;
		logic [3:0]      ncyc;
		logic [3:0]      cnt;
		logic [15:0]     rd;
		logic [7:0][7:0] regs;
		logic [7:0]      program_status_word;
		cmas_mem_s       mem;
		logic            done;
		logic            err;
		logic            ready;
		logic [15:0]     tgt;
		logic            bit_val;
		logic [3:0]      hlp;
		logic            wr_seen;
	} cmas_st_s;

endpackage

// file: verilog/cmas_core.sv
`timescale 1ns/1ps
`include "cmas_regs.svh"
module cmas_core (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                req_valid,
	input  wire cmas_pkg::cmas_req_s req,
	input  wire logic [7:0]          mem_rdata,
	output logic                     req_ready,
	output cmas_pkg::cmas_mem_s      mem,
	output logic                     done,
	output logic                     err,
	output logic [15:0]              tgt_addr,
	output logic                     bit_val,
	output logic [63:0]              reg_file,
	output logic [7:0]               program_status_word
);

	cmas_pkg::cmas_st_s st_q;
	cmas_pkg::cmas_st_s st_d;

	logic [15:0] ea_in;
	logic [3:0]  cyc_in;
	logic        bad_in;
	logic        mem_kind;
	logic        is_word;
	logic        need_rd;
	logic        need_wr;
	logic        arith;
	logic [7:0]  cur_lo;
	logic [7:0]  opa;
	logic [7:0]  opb;
	logic [10:0] alu_r;
	logic [7:0]  wbyte;
	logic [15:0] wword;
	logic [2:0]  dst_idx;

	function automatic logic [15:0] calc_ea(cmas_pkg::cmas_req_s r, logic [7:0][7:0] g);
		logic [15:0] hl;
		hl = {g[`CMAS_IDX_H], g[`CMAS_IDX_L]};
		case (r.ak)
			cmas_pkg::AK_SADDR: begin
				// Offsets below the wrap point fold into the top page
				calc_ea = {(r.addr[7:0] < `CMAS_SADDR_WRAP) ? `CMAS_PAGE_FF : `CMAS_PAGE_FE,
					r.addr[7:0]};
			end
			cmas_pkg::AK_SFR:    calc_ea = {`CMAS_PAGE_FF, r.addr[7:0]};
			cmas_pkg::AK_DE:     calc_ea = {g[`CMAS_IDX_D], g[`CMAS_IDX_E]};
			cmas_pkg::AK_HL:     calc_ea = hl;
			cmas_pkg::AK_HLBYTE: calc_ea = hl + {8'h00, r.imm[7:0]};
			cmas_pkg::AK_HLB:    calc_ea = hl + {8'h00, g[`CMAS_IDX_B]};
			cmas_pkg::AK_HLC:    calc_ea = hl + {8'h00, g[`CMAS_IDX_C]};
			cmas_pkg::AK_ELEVEN_BIT_CALL_OPERAND: calc_ea = {`CMAS_A11_BASE, r.addr[10:0]};
			cmas_pkg::AK_VECTOR_TABLE_OPERAND:  calc_ea = {9'h000, 1'b1, r.addr[4:0], 1'b0};
			default:             calc_ea = r.addr;
		endcase
	endfunction

	function automatic logic [3:0] calc_cyc(cmas_pkg::cmas_req_s r, logic [15:0] a);
		logic [3:0] x1;
		logic [3:0] x2;
		logic       hs;
		hs = (a >= `CMAS_HSRAM_LO) && (a <= `CMAS_HSRAM_HI);
		// Slow areas add a fixed penalty on top of the fast count
		x1 = hs ? 4'h0 : `CMAS_CYC_EXT1;
		x2 = hs ? 4'h0 : `CMAS_CYC_EXT2;
		if (r.ak == cmas_pkg::AK_NONE || r.ak == cmas_pkg::AK_PSW ||
			r.ak == cmas_pkg::AK_SFR) begin
			x1 = `CMAS_CYC_EXT1;
			x2 = `CMAS_CYC_EXT2;
		end
		case (r.op)
			cmas_pkg::OP_TARGET: calc_cyc = `CMAS_CYC_SHORT;
			cmas_pkg::OP_WORD_SWAP:   calc_cyc = `CMAS_CYC_SHORT;
			cmas_pkg::OP_WORD_MOVE: begin
				case (r.ak)
					cmas_pkg::AK_NONE:  calc_cyc = r.use_imm ? `CMAS_CYC_MID : `CMAS_CYC_SHORT;
					cmas_pkg::AK_SADDR: calc_cyc = (r.use_imm ? `CMAS_CYC_LONG : `CMAS_CYC_MID) + x2;
					cmas_pkg::AK_SFR:   calc_cyc = r.use_imm ? `CMAS_CYC_WABS : `CMAS_CYC_LONG;
					default:            calc_cyc = `CMAS_CYC_WABS + x2;
				endcase
			end
			cmas_pkg::OP_XCH: begin
				case (r.ak)
					cmas_pkg::AK_NONE:   calc_cyc = `CMAS_CYC_REG;
					cmas_pkg::AK_SFR:    calc_cyc = `CMAS_CYC_MID;
					cmas_pkg::AK_ABS,
					cmas_pkg::AK_HLBYTE,
					cmas_pkg::AK_HLB,
					cmas_pkg::AK_HLC:    calc_cyc = `CMAS_CYC_LONG + x2;
					default:             calc_cyc = `CMAS_CYC_SHORT + x2;
				endcase
			end
			cmas_pkg::OP_MOV: begin
				case (r.ak)
					cmas_pkg::AK_NONE:   calc_cyc = r.use_imm ? `CMAS_CYC_SHORT : `CMAS_CYC_REG;
					cmas_pkg::AK_SADDR,
					cmas_pkg::AK_SFR,
					cmas_pkg::AK_PSW: begin
						calc_cyc = (r.use_imm ? `CMAS_CYC_MID : `CMAS_CYC_SHORT) + x1;
					end
					cmas_pkg::AK_ABS,
					cmas_pkg::AK_HLBYTE: calc_cyc = `CMAS_CYC_LONG + x1;
					cmas_pkg::AK_HLB,
					cmas_pkg::AK_HLC:    calc_cyc = `CMAS_CYC_MID + x1;
					default:             calc_cyc = `CMAS_CYC_SHORT + x1;
				endcase
			end
			default: begin
				case (r.ak)
					cmas_pkg::AK_NONE:  calc_cyc = `CMAS_CYC_SHORT;
					// Read-modify-write of short direct: 6 fast, 8 slow
					cmas_pkg::AK_SADDR: calc_cyc = r.to_mem ? `CMAS_CYC_MID + x2 : `CMAS_CYC_SHORT + x1;
					cmas_pkg::AK_DE,
					cmas_pkg::AK_HL:    calc_cyc = `CMAS_CYC_SHORT + x1;
					default:            calc_cyc = `CMAS_CYC_LONG + x1;
				endcase
			end
		endcase
	endfunction

	function automatic logic calc_bad(cmas_pkg::cmas_req_s r, logic [15:0] a);
		logic word;
		logic bad;
		word = (r.op == cmas_pkg::OP_WORD_MOVE) || (r.op == cmas_pkg::OP_WORD_SWAP);
		bad  = 1'b0;
		case (r.ak)
			cmas_pkg::AK_SADDR: bad = word && a[0];
			cmas_pkg::AK_SFR: begin
				bad = (a >= `CMAS_SFR_HOLE_LO) && (a <= `CMAS_SFR_HOLE_HI);
				if (word && (a[0] || a < `CMAS_SFRP_LO || a > `CMAS_SFRP_HI))
					bad = 1'b1;
			end
			cmas_pkg::AK_ABS:    bad = word && a[0];
			cmas_pkg::AK_PSW:    bad = r.op != cmas_pkg::OP_MOV;
			cmas_pkg::AK_ELEVEN_BIT_CALL_OPERAND,
			cmas_pkg::AK_VECTOR_TABLE_OPERAND:  bad = r.op != cmas_pkg::OP_TARGET;
			cmas_pkg::AK_NONE: begin
				// The accumulator can pair with itself here only in arithmetic with a register destination
				if (!word && !r.use_imm && r.reg_sel == `CMAS_IDX_A)
					bad = (r.op == cmas_pkg::OP_MOV) || (r.op == cmas_pkg::OP_XCH) || !r.r_dst;
			end
			default:             bad = word;
		endcase
		if (r.op == cmas_pkg::OP_TARGET && r.ak != cmas_pkg::AK_ELEVEN_BIT_CALL_OPERAND &&
			r.ak != cmas_pkg::AK_VECTOR_TABLE_OPERAND)
			bad = 1'b1;
		if (r.op == cmas_pkg::OP_WORD_SWAP && r.ak != cmas_pkg::AK_NONE)
			bad = 1'b1;
		if ((r.op == cmas_pkg::OP_WORD_SWAP || (r.op == cmas_pkg::OP_WORD_MOVE && !r.use_imm)) &&
			r.ak == cmas_pkg::AK_NONE && r.rp_sel == `CMAS_RP_AX)
			bad = 1'b1;
		calc_bad = bad;
	endfunction

	function automatic logic [10:0] alu(cmas_pkg::cmas_op_e op, logic [7:0] a, logic [7:0] b,
		logic cin);
		logic [8:0] w;
		logic [4:0] h;
		logic       c;
		c = (op == cmas_pkg::OP_ADD_WITH_CARRY) ? cin : 1'b0;
		if (op == cmas_pkg::OP_SUB) begin
			// Borrow lands in the carry position
			w = {1'b0, a} - {1'b0, b};
			h = {1'b0, a[3:0]} - {1'b0, b[3:0]};
		end else begin
			w = {1'b0, a} + {1'b0, b} + {8'h00, c};
			h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
		end
		alu = {w[7:0] == 8'h00, h[4], w[8], w[7:0]};
	endfunction

	assign ea_in    = calc_ea(req, st_q.regs);
	assign cyc_in   = calc_cyc(req, ea_in);
	assign bad_in   = calc_bad(req, ea_in);
	assign mem_kind = (st_q.cmd.ak >= cmas_pkg::AK_SADDR) && (st_q.cmd.ak <= cmas_pkg::AK_HLC);
	assign is_word  = st_q.cmd.op == cmas_pkg::OP_WORD_MOVE;
	assign arith    = (st_q.cmd.op == cmas_pkg::OP_ADD) || (st_q.cmd.op == cmas_pkg::OP_ADD_WITH_CARRY) ||
		(st_q.cmd.op == cmas_pkg::OP_SUB);
	assign need_rd  = mem_kind && (st_q.cmd.op == cmas_pkg::OP_XCH || !st_q.cmd.to_mem || arith);
	assign need_wr  = mem_kind && (st_q.cmd.op == cmas_pkg::OP_XCH || st_q.cmd.to_mem);
	// Read data is usable in the very cycle it arrives, so a 4-clock arithmetic read-modify-write still fits
	assign cur_lo   = (st_q.cnt == 4'h2) ? mem_rdata : st_q.rd[7:0];
	assign opa      = (st_q.cmd.ak == cmas_pkg::AK_NONE && st_q.cmd.r_dst) ?
		st_q.regs[st_q.cmd.reg_sel] : (st_q.cmd.to_mem ? cur_lo : st_q.regs[`CMAS_IDX_A]);
	assign opb      = st_q.cmd.use_imm ? st_q.cmd.imm[7:0] :
		(st_q.cmd.ak != cmas_pkg::AK_NONE ? cur_lo :
		(st_q.cmd.r_dst ? st_q.regs[`CMAS_IDX_A] : st_q.regs[st_q.cmd.reg_sel]));
	assign alu_r    = alu(st_q.cmd.op, opa, opb, st_q.program_status_word[`CMAS_PSW_CY]);
	assign wbyte    = arith ? alu_r[7:0] :
		((st_q.cmd.op == cmas_pkg::OP_MOV && st_q.cmd.use_imm) ? st_q.cmd.imm[7:0] :
		st_q.regs[`CMAS_IDX_A]);
	assign wword    = st_q.cmd.use_imm ? st_q.cmd.imm :
		{st_q.regs[`CMAS_IDX_A], st_q.regs[`CMAS_IDX_X]};
	assign dst_idx  = (st_q.cmd.ak == cmas_pkg::AK_NONE && st_q.cmd.r_dst) ?
		st_q.cmd.reg_sel : `CMAS_IDX_A;

	always_comb begin
		st_d          = st_q;
		st_d.done     = 1'b0;
		st_d.err      = 1'b0;
		st_d.mem.req  = 1'b0;
		st_d.mem.we   = 1'b0;
		st_d.hlp      = (st_q.state == cmas_pkg::ST_RUN) ? st_q.hlp + 4'h1 : 4'h0;
		case (st_q.state)
			cmas_pkg::ST_IDLE: begin
				if (req_valid) begin
					if (bad_in) begin
						st_d.err = 1'b1;
					end else begin
						st_d.state   = cmas_pkg::ST_RUN;
						st_d.cmd     = req;
						st_d.ea      = ea_in;
						st_d.ncyc    = cyc_in;
						st_d.cnt     = 4'h0;
						st_d.ready   = 1'b0;
						st_d.wr_seen = 1'b0;
					end
				end
			end
			cmas_pkg::ST_RUN: begin
				st_d.cnt = st_q.cnt + 4'h1;
				if (need_rd && st_q.cnt == 4'h0) begin
					st_d.mem.req  = 1'b1;
					st_d.mem.addr = st_q.ea;
				end
				if (need_rd && is_word && st_q.cnt == 4'h1) begin
					st_d.mem.req  = 1'b1;
					st_d.mem.addr = st_q.ea + 16'h0001;
				end
				if (need_rd && st_q.cnt == 4'h2)
					st_d.rd[7:0] = mem_rdata;
				if (need_rd && st_q.cnt == 4'h3)
					st_d.rd[15:8] = mem_rdata;
				if (need_wr && is_word && st_q.cnt == st_q.ncyc - 4'h3) begin
					st_d.mem       = '{req: 1'b1, we: 1'b1, addr: st_q.ea, wdata: wword[7:0]};
					st_d.wr_seen   = 1'b1;
				end
				if (need_wr && is_word && st_q.cnt == st_q.ncyc - 4'h2) begin
					st_d.mem.req   = 1'b1;
					st_d.mem.we    = 1'b1;
					st_d.mem.addr  = st_q.ea + 16'h0001;
					st_d.mem.wdata = wword[15:8];
				end
				// Swap write lands inside the same instruction as its read
				if (need_wr && !is_word && st_q.cnt == st_q.ncyc - 4'h2) begin
					st_d.mem     = '{req: 1'b1, we: 1'b1, addr: st_q.ea, wdata: wbyte};
					st_d.wr_seen = 1'b1;
				end
				if (st_q.cnt == st_q.ncyc - 4'h1) begin
					case (st_q.cmd.op)
						cmas_pkg::OP_MOV: begin
							if (st_q.cmd.ak == cmas_pkg::AK_NONE) begin
								st_d.regs[dst_idx] = st_q.cmd.use_imm ? st_q.cmd.imm[7:0] :
									(st_q.cmd.r_dst ? st_q.regs[`CMAS_IDX_A] :
									st_q.regs[st_q.cmd.reg_sel]);
							end else if (st_q.cmd.ak == cmas_pkg::AK_PSW) begin
								// Among moves, only those into the status word touch the flags
								if (st_q.cmd.to_mem)
									st_d.program_status_word = st_q.cmd.use_imm ? st_q.cmd.imm[7:0] :
										st_q.regs[`CMAS_IDX_A];
								else
									st_d.regs[`CMAS_IDX_A] = st_q.program_status_word;
							end else if (!st_q.cmd.to_mem) begin
								st_d.regs[`CMAS_IDX_A] = st_q.rd[7:0];
							end
						end
						cmas_pkg::OP_XCH: begin
							st_d.regs[`CMAS_IDX_A] = (st_q.cmd.ak == cmas_pkg::AK_NONE) ?
								st_q.regs[st_q.cmd.reg_sel] : st_q.rd[7:0];
							if (st_q.cmd.ak == cmas_pkg::AK_NONE)
								st_d.regs[st_q.cmd.reg_sel] = st_q.regs[`CMAS_IDX_A];
						end
						cmas_pkg::OP_WORD_MOVE,
						cmas_pkg::OP_WORD_SWAP: begin
							if (st_q.cmd.ak != cmas_pkg::AK_NONE) begin
								if (!st_q.cmd.to_mem)
									{st_d.regs[`CMAS_IDX_A], st_d.regs[`CMAS_IDX_X]} = st_q.rd;
							end else if (st_q.cmd.r_dst || st_q.cmd.op == cmas_pkg::OP_WORD_SWAP) begin
								// Pair n lives in registers 2n+1 (high) and 2n (low)
								{st_d.regs[{st_q.cmd.rp_sel, 1'b1}],
									st_d.regs[{st_q.cmd.rp_sel, 1'b0}]} = wword;
							end
							if (st_q.cmd.ak == cmas_pkg::AK_NONE &&
								(!st_q.cmd.r_dst || st_q.cmd.op == cmas_pkg::OP_WORD_SWAP))
								{st_d.regs[`CMAS_IDX_A], st_d.regs[`CMAS_IDX_X]} =
									{st_q.regs[{st_q.cmd.rp_sel, 1'b1}],
									st_q.regs[{st_q.cmd.rp_sel, 1'b0}]};
						end
						cmas_pkg::OP_TARGET: st_d.tgt = st_q.ea;
						default: begin
							if (!st_q.cmd.to_mem)
								st_d.regs[dst_idx] = alu_r[7:0];
							st_d.program_status_word[`CMAS_PSW_Z]  = alu_r[10];
							st_d.program_status_word[`CMAS_PSW_AC] = alu_r[9];
							st_d.program_status_word[`CMAS_PSW_CY] = alu_r[8];
						end
					endcase
					st_d.bit_val = st_d.regs[`CMAS_IDX_A][st_q.cmd.bit_pos];
					st_d.done    = 1'b1;
					st_d.ready   = 1'b1;
					st_d.state   = cmas_pkg::ST_IDLE;
				end
			end
			default: st_d.state = cmas_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q       <= '0;
			st_q.state <= cmas_pkg::ST_IDLE;
			st_q.regs  <= {8{`CMAS_RST_BYTE}};
			st_q.program_status_word   <= `CMAS_RST_PSW;
			st_q.ready <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign req_ready = st_q.ready;
	assign mem       = st_q.mem;
	assign done      = st_q.done;
	assign err       = st_q.err;
	assign tgt_addr  = st_q.tgt;
	assign bit_val   = st_q.bit_val;
	assign reg_file  = st_q.regs;
	assign program_status_word       = st_q.program_status_word;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_saddr_window: assert property (
		st_q.mem.req && st_q.cmd.ak == cmas_pkg::AK_SADDR |->
		st_q.mem.addr >= `CMAS_SADDR_LO && st_q.mem.addr <= `CMAS_SADDR_HI)
		else $error("short direct access outside its window");

	chk_sfr_hole: assert property (
		st_q.mem.req && st_q.cmd.ak == cmas_pkg::AK_SFR |->
		!(st_q.mem.addr >= `CMAS_SFR_HOLE_LO && st_q.mem.addr <= `CMAS_SFR_HOLE_HI))
		else $error("special register access into the barred range");

	chk_far_target: assert property (
		st_q.done && st_q.cmd.op == cmas_pkg::OP_TARGET && st_q.cmd.ak == cmas_pkg::AK_ELEVEN_BIT_CALL_OPERAND |->
		st_q.tgt >= `CMAS_A11_LO && st_q.tgt <= `CMAS_A11_HI)
		else $error("eleven-bit target out of range");

	chk_vector_even: assert property (
		st_q.done && st_q.cmd.op == cmas_pkg::OP_TARGET && st_q.cmd.ak == cmas_pkg::AK_VECTOR_TABLE_OPERAND |->
		!st_q.tgt[0] && st_q.tgt >= `CMAS_A5_LO && st_q.tgt <= `CMAS_A5_HI)
		else $error("vector target odd or out of range");

	chk_cycle_total: assert property (
		st_q.done |-> st_q.hlp == st_q.ncyc && st_q.ncyc >= `CMAS_CYC_REG)
		else $error("instruction length differs from its clock count");

	chk_move_flags: assert property (
		st_q.done && (st_q.cmd.op == cmas_pkg::OP_MOV || st_q.cmd.op == cmas_pkg::OP_XCH) &&
		st_q.cmd.ak != cmas_pkg::AK_PSW |-> st_q.program_status_word == $past(st_q.program_status_word))
		else $error("move changed the flags");

	chk_add_rmw: assert property (
		st_q.done && st_q.cmd.op == cmas_pkg::OP_ADD && st_q.cmd.to_mem |->
		st_q.wr_seen && (st_q.ncyc == 4'h6 || st_q.ncyc == 4'h8))
		else $error("add to short direct wrong length or no write back");

	chk_word_even: assert property (
		st_q.state == cmas_pkg::ST_RUN && is_word &&
		(st_q.cmd.ak == cmas_pkg::AK_ABS || st_q.cmd.ak == cmas_pkg::AK_SADDR) |-> !st_q.ea[0])
		else $error("word access at odd address");

	chk_swap_atomic: assert property (
		req_valid && st_q.ready && !bad_in && req.op == cmas_pkg::OP_XCH &&
		req.ak != cmas_pkg::AK_NONE |=> !st_q.ready [*2] ##[1:8] st_q.done && st_q.wr_seen)
		else $error("swap finished without its write");

endmodule

// file: verif/cmas_core_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module cmas_core_tb;
	logic                clk             = 1'b0;
	logic                rst_n           = 1'b0;
	logic                req_valid       = 1'b0;
	cmas_pkg::cmas_req_s req             = '0;
	logic [7:0]          mem_rdata       = 8'h00;
	logic                req_ready;
	cmas_pkg::cmas_mem_s mem;
	logic                done;
	logic                err;
	logic [15:0]         tgt_addr;
	logic                bit_val;
	logic [63:0]         reg_file;
	logic [7:0]          program_status_word;
	logic [7:0]          ram [0:65535];
	int                  num_errors      = 0;
	int                  samples_checked = 0;
	int                  cycles          = 0;
	int                  n;

	cmas_core cmas_core_inst (
		.clk       (clk),
		.rst_n     (rst_n),
		.req_valid (req_valid),
		.req       (req),
		.mem_rdata (mem_rdata),
		.req_ready (req_ready),
		.mem       (mem),
		.done      (done),
		.err       (err),
		.tgt_addr  (tgt_addr),
		.bit_val   (bit_val),
		.reg_file  (reg_file),
		.program_status_word       (program_status_word)
	);

	always #4 clk = ~clk;

	// Memory answers a cycle after a read; idle cycles toggle the data so stale bytes never match
	always @(posedge clk) begin
		if (mem.req && !mem.we)
			mem_rdata <= ram[mem.addr];
		else
			mem_rdata <= ~mem_rdata;
		if (mem.req && mem.we)
			ram[mem.addr] <= mem.wdata;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles > 3000) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		$display("errors=%0d checks=%0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	function automatic logic [7:0] rg(input int i);
		return reg_file[8*i +: 8];
	endfunction

	// Flag bits: imm source, memory destination, register destination
	function automatic cmas_pkg::cmas_req_s mk(cmas_pkg::cmas_op_e o, cmas_pkg::cmas_ak_e k,
			logic [2:0] f, logic [2:0] s, logic [15:0] a, logic [15:0] i);
		mk = '0;
		mk.op = o;
		mk.ak = k;
		{mk.use_imm, mk.to_mem, mk.r_dst} = f;
		mk.reg_sel = s;
		mk.rp_sel = s[1:0];
		mk.addr = a;
		mk.imm = i;
	endfunction

	// Accepting edge counts as 1: done seen at N+1, a refusal at 1
	// Err stands only in the cycle right after acceptance, so look there first
	task automatic run(input cmas_pkg::cmas_req_s r, input int exp_n);
		@(posedge clk);
		req <= r;
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		n = 1;
		#1;
		while (done !== 1'b1 && err !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
			#1;
		end
		`CHK(n, exp_n)
		`CHK({done, err}, {exp_n != 1, exp_n == 1})
	endtask

	task automatic t_regs;
		cmas_pkg::cmas_req_s r;
		for (int i = 0; i < 8; i++) begin
			run(mk(cmas_pkg::OP_MOV, cmas_pkg::AK_NONE, 3'b101, i[2:0], 0, 16'(8'h11*(i+1))), 5);
			`CHK(rg(i), 8'(8'h11*(i+1)))
		end
		`CHK(program_status_word, 8'h00)
		run(mk(cmas_pkg::OP_MOV, cmas_pkg::AK_NONE, 3'b000, 3'd7, 0, 0), 3);
		`CHK(rg(1), 8'h88)
		run(mk(cmas_pkg::OP_MOV, cmas_pkg::AK_NONE, 3'b000, 3'd1, 0, 0), 1);
		for (int i = 0; i < 8; i++) begin
			r = mk(cmas_pkg::OP_MOV, cmas_pkg::AK_NONE, 3'b101, 3'd0, 0, 16'h00EE);
			r.bit_pos = i[2:0];
			run(r, 5);
			`CHK(bit_val, i == 3 || i == 7)
		end
	endtask

	task automatic t_saddr;
		ram[16'hFE20] = 8'h5A;
		ram[16'hFF1F] = 8'hA5;
		run(mk(cmas_pkg::OP_MOV, cmas_pkg::AK_SADDR, 3'b000, 0, 16'h0020, 0), 5);
		`CHK(rg(1), 8'h5A)
		run(mk(cmas_pkg::OP_MOV, cmas_pkg::AK_SADDR, 3'b000, 0, 16'h001F, 0), 6);
		`CHK(rg(1), 8'hA5)
		run(mk(cmas_pkg::OP_MOV, cmas_pkg::AK_SADDR, 3'b010, 0, 16'h0020, 0), 5);
		`CHK(ram[16'hFE20], 8'hA5)
		ram[16'hFFCF] = 8'h3E;
		run(mk(cmas_pkg::OP_MOV, cmas_pkg::AK_SFR, 3'b000, 0, 16'h00CF, 0), 6);
		`CHK(rg(1), 8'h3E)
	endtask

	task automatic t_arith;
		run(mk(cmas_pkg::OP_MOV, cmas_pkg::AK_PSW, 3'b110, 0, 0, 16'h0051), 8);
		`CHK(program_status_word, 8'h51)
		run(mk(cmas_pkg::OP_MOV, cmas_pkg::AK_PSW, 3'b110, 0, 0, 16'h0000), 8);
		ram[16'hFE40] = 8'hF8;
		run(mk(cmas_pkg::OP_ADD, cmas_pkg::AK_SADDR, 3'b110, 0, 16'h0040, 16'h0009), 7);
		`CHK(ram[16'hFE40], 8'h01)
		`CHK(program_status_word, 8'h11)
		ram[16'hFF00] = 8'h80;
		run(mk(cmas_pkg::OP_ADD, cmas_pkg::AK_SADDR, 3'b110, 0, 16'h0000, 16'h0080), 9);
		`CHK(ram[16'hFF00], 8'h00)
		`CHK(program_status_word, 8'h41)
		run(mk(cmas_pkg::OP_MOV, cmas_pkg::AK_NONE, 3'b101, 3'd1, 0, 16'h0001), 5);
		run(mk(cmas_pkg::OP_ADD_WITH_CARRY, cmas_pkg::AK_NONE, 3'b100, 0, 0, 16'h000E), 5);
		`CHK(rg(1), 8'h10)
		`CHK(program_status_word, 8'h10)
		ram[16'hFE60] = 8'hFF;
		run(mk(cmas_pkg::OP_ADD_WITH_CARRY, cmas_pkg::AK_SADDR, 3'b110, 0, 16'h0060, 16'h0001), 7);
		`CHK(ram[16'hFE60], 8'h00)
		`CHK(program_status_word, 8'h51)
		ram[16'hFE50] = 8'h00;
		run(mk(cmas_pkg::OP_SUB, cmas_pkg::AK_SADDR, 3'b110, 0, 16'h0050, 16'h0001), 7);
		`CHK(ram[16'hFE50], 8'hFF)
		`CHK(program_status_word, 8'h11)
		ram[16'hFF02] = 8'h35;
		run(mk(cmas_pkg::OP_SUB, cmas_pkg::AK_SADDR, 3'b110, 0, 16'h0002, 16'h0035), 9);
		`CHK(program_status_word, 8'h40)
		run(mk(cmas_pkg::OP_ADD, cmas_pkg::AK_NONE, 3'b000, 3'd1, 0, 0), 1);
	endtask

	task automatic t_swap;
		run(mk(cmas_pkg::OP_MOV, cmas_pkg::AK_NONE, 3'b101, 3'd1, 0, 16'h003C), 5);
		ram[16'hFE80] = 8'hC3;
		run(mk(cmas_pkg::OP_XCH, cmas_pkg::AK_SADDR, 3'b000, 0, 16'h0080, 0), 5);
		`CHK({rg(1), ram[16'hFE80]}, 16'hC33C)
		ram[16'hFF04] = 8'h77;
		run(mk(cmas_pkg::OP_XCH, cmas_pkg::AK_SADDR, 3'b000, 0, 16'h0004, 0), 7);
		`CHK({rg(1), ram[16'hFF04]}, 16'h77C3)
		`CHK(program_status_word, 8'h40)
	endtask

	task automatic t_word;
		run(mk(cmas_pkg::OP_MOV, cmas_pkg::AK_NONE, 3'b101, 3'd0, 0, 16'h0034), 5);
		run(mk(cmas_pkg::OP_MOV, cmas_pkg::AK_NONE, 3'b101, 3'd1, 0, 16'h0012), 5);
		run(mk(cmas_pkg::OP_WORD_MOVE, cmas_pkg::AK_NONE, 3'b001, 3'd1, 0, 0), 5);
		`CHK({rg(3), rg(2)}, 16'h1234)
		run(mk(cmas_pkg::OP_WORD_MOVE, cmas_pkg::AK_NONE, 3'b001, 3'd3, 0, 0), 5);
		`CHK({rg(7), rg(6)}, 16'h1234)
		run(mk(cmas_pkg::OP_WORD_SWAP, cmas_pkg::AK_NONE, 3'b000, 3'd2, 0, 0), 5);
		`CHK({rg(1), rg(0), rg(5), rg(4)}, 32'h6655_1234)
		run(mk(cmas_pkg::OP_WORD_MOVE, cmas_pkg::AK_NONE, 3'b001, 3'd0, 0, 0), 1);
		run(mk(cmas_pkg::OP_WORD_SWAP, cmas_pkg::AK_NONE, 3'b000, 3'd0, 0, 0), 1);
		ram[16'h1000] = 8'h78;
		ram[16'h1001] = 8'h9A;
		run(mk(cmas_pkg::OP_WORD_MOVE, cmas_pkg::AK_ABS, 3'b000, 0, 16'h1000, 0), 13);
		`CHK({rg(1), rg(0)}, 16'h9A78)
	endtask

	task automatic t_refuse;
		cmas_pkg::cmas_req_s bad [7];
		bad[0] = mk(cmas_pkg::OP_WORD_MOVE, cmas_pkg::AK_SADDR, 3'b000, 0, 16'h0021, 0);
		bad[1] = mk(cmas_pkg::OP_MOV, cmas_pkg::AK_SFR, 3'b000, 0, 16'h00D0, 0);
		bad[2] = mk(cmas_pkg::OP_MOV, cmas_pkg::AK_SFR, 3'b010, 0, 16'h00DF, 0);
		bad[3] = mk(cmas_pkg::OP_WORD_MOVE, cmas_pkg::AK_SFR, 3'b000, 0, 16'h0013, 0);
		bad[4] = mk(cmas_pkg::OP_WORD_MOVE, cmas_pkg::AK_SFR, 3'b000, 0, 16'h00E0, 0);
		bad[5] = mk(cmas_pkg::OP_WORD_MOVE, cmas_pkg::AK_ABS, 3'b000, 0, 16'h1001, 0);
		bad[6] = mk(cmas_pkg::OP_MOV, cmas_pkg::AK_ELEVEN_BIT_CALL_OPERAND, 3'b000, 0, 16'h0100, 0);
		for (int i = 0; i < 7; i++)
			run(bad[i], 1);
		`CHK({rg(1), rg(0)}, 16'h9A78)
	endtask

	task automatic t_target;
		cmas_pkg::cmas_ak_e k [4] = '{cmas_pkg::AK_ELEVEN_BIT_CALL_OPERAND, cmas_pkg::AK_ELEVEN_BIT_CALL_OPERAND,
			cmas_pkg::AK_VECTOR_TABLE_OPERAND, cmas_pkg::AK_VECTOR_TABLE_OPERAND};
		logic [15:0] a [4] = '{16'h07FF, 16'h0000, 16'h001F, 16'h0000};
		logic [15:0] t [4] = '{16'h0FFF, 16'h0800, 16'h007E, 16'h0040};
		for (int i = 0; i < 4; i++) begin
			run(mk(cmas_pkg::OP_TARGET, k[i], 3'b000, 0, a[i], 0), 5);
			`CHK(tgt_addr, t[i])
		end
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		`CHK(reg_file, 64'h0000_0000_0000_0000)
		`CHK(program_status_word, 8'h00)
		`CHK(req_ready, 1'b1)
		t_regs();
		t_saddr();
		t_arith();
		t_swap();
		t_word();
		t_refuse();
		t_target();
		end_of_test();
	end
endmodule
